// [verilog/fcm_defines.vh]
// Register map, field positions and timing constants of the fast counter block
`ifndef FCM_DEFINES_VH
`define FCM_DEFINES_VH
// ----------------------------------------
// Register offsets inside one channel
// ----------------------------------------
`define FCM_OFF_CTRL 6'h00
`define FCM_OFF_HIGH 6'h04
`define FCM_OFF_LOW 6'h08
`define FCM_OFF_START 6'h0C
`define FCM_OFF_CMP 6'h10
`define FCM_OFF_HYST 6'h14
`define FCM_OFF_UPDATE 6'h18
`define FCM_OFF_COUNT 6'h1C
`define FCM_OFF_CAPTURE 6'h20
`define FCM_OFF_MEAS 6'h24
`define FCM_OFF_STATUS 6'h28
// ----------------------------------------
// Control word fields
// ----------------------------------------
`define FCM_C_SWGATE 0
`define FCM_C_HWEN 1
`define FCM_C_DIRSW 2
`define FCM_C_SWDOWN 3
`define FCM_C_STOPLIM 4
`define FCM_C_OPPOSITE 5
`define FCM_C_STARTGATE 6
`define FCM_C_SYNCEN 7
`define FCM_C_CAPLO 8
`define FCM_C_CAPREL 10
`define FCM_C_ENCLO 11
`define FCM_C_MEASLO 13
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define FCM_RST_HIGH 32'h7FFF_FFFF
`define FCM_RST_LOW 32'h8000_0000
`define FCM_RST_ZERO 32'h0000_0000
`define FCM_CLK_KHZ 10000
`define FCM_UPDATE_MS 10
`define FCM_UPDATE_CYC (`FCM_UPDATE_MS * `FCM_CLK_KHZ)
`endif

// [verilog/fcm_fast_counter.v]
// Six channel fast counter with measurement, behind an APB slave
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fcm_defines.vh"

// Summary of operation
// RULE1: Six channels, four with A/B/N quadrature
// RULE2: Two auxiliary inputs, one output per channel
// RULE3: Quadrature, pulse+direction, pulse, up/down pulses
// RULE4: Count is a signed 32-bit register
// RULE5: Runtime-writable limits across full signed range
// RULE6: Direction from encoder or program setting
// RULE7: On limit violation continue or stop gate
// RULE8: On violation reload start or opposite limit
// RULE9: Start value clamped to limits, runtime writable
// RULE10: Start value loaded on sync/capture/limit/gate
// RULE11: Count only while combined gate open
// RULE12: Pin gate optional, program gate always active
// RULE13: Capture latches count on selected trigger
// RULE14: After capture continue or reload start
// RULE15: Output switches on count without software
// RULE16: Hysteresis band stops repeated output switching
// RULE17: Frequency mode gives float per-interval rate
// RULE18: Period and velocity modes give float results
// RULE19: Free-running update timer, not gate aligned
// RULE20: Last measured value kept after gate closes
// RULE21: Measuring range covers slow and fast inputs
// RULE22: Measured values signed by count direction
// RULE23: Count and measured value readable every cycle
module fcm_fast_counter #(
    parameter NCH = 6,
    parameter NQUAD = 4,
    parameter [31:0] UPDATE_CYCLES = `FCM_UPDATE_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [NCH-1:0] enc_a,
    input wire [NCH-1:0] enc_b,
    input wire [NQUAD-1:0] enc_n,
    input wire [2*NCH-1:0] counter_aux_input,
    output wire [NCH-1:0] counter_out
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Signed integer to single precision float, truncating low bits
    function [31:0] fcm_to_float;
        input [31:0] v;
        reg [31:0] mag;
        reg [31:0] sh;
        reg [7:0] msb;
        integer i;
        begin
            mag = v[31] ? (~v + 32'h0000_0001) : v;
            msb = 8'h00;
            for (i = 0; i < 32; i = i + 1)
            begin
                if (mag[i])
                begin
                    msb = i[7:0];
                end
            end
            sh = mag << (8'd31 - msb);
            if (mag == 32'h0000_0000)
            begin
                fcm_to_float = 32'h0000_0000;
            end
            else
            begin
                fcm_to_float = {v[31], 8'd127 + msb, sh[30:8]};
            end
        end
    endfunction

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Pins are asynchronous; stage m feeds only stage s, d is the edge history
    reg [NCH-1:0] a_m, a_s, a_d, b_m, b_s, b_d;
    reg [NQUAD-1:0] n_m, n_s, n_d;
    reg [2*NCH-1:0] x_m, x_s, x_d;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a_m <= {NCH{1'b0}};
            a_s <= {NCH{1'b0}};
            a_d <= {NCH{1'b0}};
            b_m <= {NCH{1'b0}};
            b_s <= {NCH{1'b0}};
            b_d <= {NCH{1'b0}};
            n_m <= {NQUAD{1'b0}};
            n_s <= {NQUAD{1'b0}};
            n_d <= {NQUAD{1'b0}};
            x_m <= {2*NCH{1'b0}};
            x_s <= {2*NCH{1'b0}};
            x_d <= {2*NCH{1'b0}};
        end
        else if (clk_en)
        begin
            a_m <= enc_a;
            a_s <= a_m;
            a_d <= a_s;
            b_m <= enc_b;
            b_s <= b_m;
            b_d <= b_s;
            n_m <= enc_n;
            n_s <= n_m;
            n_d <= n_s;
            x_m <= counter_aux_input;
            x_s <= x_m;
            x_d <= x_s;
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // No wait state: pready rises in the first access cycle
    wire [2:0] sel_ch = paddr[8:6];
    wire [5:0] sel_off = paddr[5:0];
    wire acc = psel & penable & pready;
    wire wr_go = acc & pwrite;
    wire [31:0] rd_ch [0:NCH-1];
    wire hit = (paddr[11:9] == 3'h0) && (sel_ch < NCH) && (paddr[1:0] == 2'h0)
        && (sel_off <= `FCM_OFF_STATUS);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            pready <= psel & ~penable & ~pready;
            if (psel & ~penable & ~pready)
            begin
                pslverr <= ~hit;
                prdata <= (hit && !pwrite) ? rd_ch[sel_ch] : 32'h0000_0000; // RULE23
            end
            else if (acc)
            begin
                pslverr <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Counter channels
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : ch // RULE1
            reg [15:0] ctrl;
            reg [31:0] hi, lo, st, cmp, hys, upd;
            reg [31:0] cnt, cap, meas, delta, per, lastper, win;
            reg stopped, gate_d, dout, lastdn;
            wire wr = wr_go & hit & (sel_ch == g);
            wire has_n = (g < NQUAD);
            // Modulo keeps the index legal on channels that have no zero track
            wire n_rise = has_n ? (n_s[g % NQUAD] & ~n_d[g % NQUAD]) : 1'b0;
            wire x0 = x_s[2*g];
            wire x1 = x_s[2*g+1];
            wire x1_r = x1 & ~x_d[2*g+1];
            wire x1_f = ~x1 & x_d[2*g+1];
            wire a_r = a_s[g] & ~a_d[g];
            wire b_r = b_s[g] & ~b_d[g];
            wire [1:0] mraw = ctrl[`FCM_C_ENCLO+1:`FCM_C_ENCLO];
            // Channels without zero track fall back to pulse+direction
            wire [1:0] mode = (!has_n && mraw == 2'd0) ? 2'd1 : mraw; // RULE1
            wire [1:0] capm = ctrl[`FCM_C_CAPLO+1:`FCM_C_CAPLO];
            reg ev, up;
            always @*
            begin
                ev = 1'b0;
                up = 1'b1;
                case (mode) // RULE3
                    2'd0:
                    begin
                        ev = (a_s[g] ^ a_d[g]) ^ (b_s[g] ^ b_d[g]);
                        up = a_s[g] ^ b_d[g];
                    end
                    2'd1:
                    begin
                        ev = a_r;
                        up = ~b_s[g];
                    end
                    2'd2:
                    begin
                        ev = a_r;
                        up = ~ctrl[`FCM_C_SWDOWN];
                    end
                    default:
                    begin
                        ev = a_r ^ b_r;
                        up = a_r;
                    end
                endcase
                if (ctrl[`FCM_C_DIRSW] && mode != 2'd3)
                begin
                    up = ~ctrl[`FCM_C_SWDOWN]; // RULE6
                end
            end
            wire gate_req = ctrl[`FCM_C_SWGATE] & (~ctrl[`FCM_C_HWEN] | x0); // RULE12
            wire gate = gate_req & ~stopped; // RULE11
            wire gate_open = gate & ~gate_d;
            wire step = gate & ev;
            wire at_hi = ($signed(cnt) >= $signed(hi));
            wire at_lo = ($signed(cnt) <= $signed(lo));
            wire viol = step & (up ? at_hi : at_lo);
            wire cap_ev = (capm == 2'd0) ? x1_r : (capm == 2'd1) ? x1_f :
                (capm == 2'd2) ? (x1_r | x1_f) : n_rise; // RULE13
            wire sync_ev = ctrl[`FCM_C_SYNCEN] & n_rise;
            wire load_st = sync_ev | (cap_ev & ctrl[`FCM_C_CAPREL])
                | (gate_open & ctrl[`FCM_C_STARTGATE]); // RULE10 RULE14
            wire [31:0] lim_rel = ctrl[`FCM_C_OPPOSITE] ? (up ? lo : hi) : st; // RULE8
            wire [31:0] stc = ($signed(pwdata) > $signed(hi)) ? hi :
                ($signed(pwdata) < $signed(lo)) ? lo : pwdata; // RULE9
            wire [31:0] thr_off = cmp - hys;
            wire win_end = (win >= upd - 32'h0000_0001);
            wire [31:0] sper = lastdn ? (~lastper + 32'h0000_0001) : lastper;

            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    ctrl <= 16'h0000;
                    hi <= `FCM_RST_HIGH;
                    lo <= `FCM_RST_LOW;
                    st <= `FCM_RST_ZERO;
                    cmp <= `FCM_RST_ZERO;
                    hys <= `FCM_RST_ZERO;
                    upd <= UPDATE_CYCLES;
                    cnt <= `FCM_RST_ZERO;
                    cap <= `FCM_RST_ZERO;
                    meas <= `FCM_RST_ZERO;
                    delta <= `FCM_RST_ZERO;
                    per <= `FCM_RST_ZERO;
                    lastper <= `FCM_RST_ZERO;
                    win <= `FCM_RST_ZERO;
                    stopped <= 1'b0;
                    gate_d <= 1'b0;
                    dout <= 1'b0;
                    lastdn <= 1'b0;
                end
                else if (clk_en)
                begin
                    gate_d <= gate;
                    // Program registers
                    if (wr && sel_off == `FCM_OFF_CTRL)
                    begin
                        ctrl <= pwdata[15:0];
                    end
                    if (wr && sel_off == `FCM_OFF_HIGH)
                    begin
                        hi <= pwdata; // RULE5
                    end
                    if (wr && sel_off == `FCM_OFF_LOW)
                    begin
                        lo <= pwdata; // RULE5
                    end
                    if (wr && sel_off == `FCM_OFF_START)
                    begin
                        st <= stc; // RULE9
                    end
                    if (wr && sel_off == `FCM_OFF_CMP)
                    begin
                        cmp <= pwdata;
                    end
                    if (wr && sel_off == `FCM_OFF_HYST)
                    begin
                        hys <= pwdata;
                    end
                    if (wr && sel_off == `FCM_OFF_UPDATE)
                    begin
                        upd <= (pwdata == 32'h0000_0000) ? 32'h0000_0001 : pwdata;
                    end
                    // Limit stop releases only when the requested gate drops
                    if (viol && ctrl[`FCM_C_STOPLIM])
                    begin
                        stopped <= 1'b1; // RULE7
                    end
                    else if (!gate_req)
                    begin
                        stopped <= 1'b0;
                    end
                    // Capture takes the count before any reload this cycle
                    if (cap_ev)
                    begin
                        cap <= cnt; // RULE13
                    end
                    // Count value, reload has priority over a step
                    if (load_st)
                    begin
                        cnt <= st; // RULE10
                    end
                    else if (viol)
                    begin
                        cnt <= lim_rel; // RULE8
                    end
                    else if (step)
                    begin
                        cnt <= up ? cnt + 32'h0000_0001 : cnt - 32'h0000_0001; // RULE4
                    end
                    // Output with hysteresis: on at cmp, off only below cmp-hys
                    if ($signed(cnt) >= $signed(cmp))
                    begin
                        dout <= 1'b1; // RULE15
                    end
                    else if ($signed(cnt) < $signed(thr_off))
                    begin
                        dout <= 1'b0; // RULE16
                    end
                    // Pulse timing for the period result
                    if (step)
                    begin
                        lastper <= per + 32'h0000_0001;
                        lastdn <= ~up;
                        per <= 32'h0000_0000;
                    end
                    else if (per != 32'hFFFF_FFFF)
                    begin
                        per <= per + 32'h0000_0001;
                    end
                    // Update timer free runs; it never restarts on gate open
                    if (win_end)
                    begin
                        win <= 32'h0000_0000; // RULE19
                        delta <= step ? (up ? 32'h0000_0001 : 32'hFFFF_FFFF) : 32'h0000_0000;
                        // Closed gate keeps the previous result
                        if (gate)
                        begin
                            if (ctrl[`FCM_C_MEASLO+1:`FCM_C_MEASLO] == 2'd1)
                            begin
                                meas <= fcm_to_float(sper); // RULE18 RULE22
                            end
                            else
                            begin
                                meas <= fcm_to_float(delta); // RULE17 RULE18 RULE22
                            end
                        end // RULE20
                    end
                    else
                    begin
                        win <= win + 32'h0000_0001;
                        if (step)
                        begin
                            delta <= up ? delta + 32'h0000_0001 : delta - 32'h0000_0001; // RULE22
                        end
                    end
                end
            end

            assign counter_out[g] = dout; // RULE2
            // Readback mux; 32-bit counters cover the slowest period range
            assign rd_ch[g] = (sel_off == `FCM_OFF_CTRL) ? {16'h0000, ctrl} :
                (sel_off == `FCM_OFF_HIGH) ? hi :
                (sel_off == `FCM_OFF_LOW) ? lo :
                (sel_off == `FCM_OFF_START) ? st :
                (sel_off == `FCM_OFF_CMP) ? cmp :
                (sel_off == `FCM_OFF_HYST) ? hys :
                (sel_off == `FCM_OFF_UPDATE) ? upd :
                (sel_off == `FCM_OFF_COUNT) ? cnt :
                (sel_off == `FCM_OFF_CAPTURE) ? cap :
                (sel_off == `FCM_OFF_MEAS) ? meas :
                {28'h000_0000, dout, stopped, gate, lastdn}; // RULE21 RULE23
        end
    endgenerate

endmodule
`default_nettype wire

// [testbench/fcm_fast_counter_props.sv]
// Bus answer checks on the fast counter ports
`timescale 1ns/1ps
`default_nettype none
module fcm_fast_counter_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic bad;
    assign bad = paddr[11:9] != 3'h0 || paddr[8:6] > 3'h5 || paddr[5:0] > 6'h28 || paddr[1:0] != 2'h0;
    sequence s_setup;
        psel && !penable && !pready && clk_en;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_setup_answered: assert property (s_setup |=> s_answer)
        else $error("setup not answered by one ready pulse");
    a_idle_quiet: assert property (!psel && clk_en |=> !pready)
        else $error("ready without select");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_rose_after_setup: assert property ($rose(pready) |-> $past(psel) && !$past(penable))
        else $error("ready rose without setup");
    a_err_needs_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_on_bad: assert property (pready && bad |-> pslverr)
        else $error("bad address accepted");
    a_ok_on_good: assert property (pready && !bad |-> !pslverr)
        else $error("good address refused");
    a_err_data_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
        else $error("data on refused read");
endmodule
bind fcm_fast_counter fcm_fast_counter_props u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// [testbench/fcm_enc_model.sv]
// Encoder model for one channel: quadrature or pulse tracks
`timescale 1ns/1ps
`default_nettype none
module fcm_enc_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic step,
    input wire logic down,
    input wire logic [1:0] mode,
    output logic a,
    output logic b
);
    logic [1:0] ph;
    logic [1:0] pw;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph <= 2'h0;
            pw <= 2'h0;
        end
        else if (step)
        begin
            ph <= down ? ph - 2'h1 : ph + 2'h1;
            pw <= 2'h2;
        end
        else if (pw != 2'h0)
            pw <= pw - 2'h1;
    end
    // Gray order so only one track moves per step; A leads when counting up
    always_comb
    begin
        if (mode == 2'h0)
        begin
            a = ph[1] ^ ph[0];
            b = ph[1];
        end
        else
        begin
            a = pw != 2'h0 && !(mode == 2'h3 && down);
            b = mode == 2'h1 ? down : (mode == 2'h3 && down && pw != 2'h0);
        end
    end
endmodule
`default_nettype wire

// [testbench/fcm_fast_counter_bench.sv]
// Self-checking bench for the six channel fast counter
`timescale 1ns/1ps
`default_nettype none
module fcm_fast_counter_bench;
    localparam logic [31:0] UP = 32'h0000_0010;
    localparam logic [31:0] Z = 32'h0000_0000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, step, down, ea, eb;
    logic clk_en;
    logic [11:0] paddr, aux;
    logic [31:0] pwdata, prdata, rd, m1;
    logic [5:0] counter_out;
    logic [1:0] emode;
    int mismatches = 0;
    int samples_checked = 0;
    logic [11:0] ra [12] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C,
        12'h144, 12'h02C, 12'h180, 12'h001};
    logic [31:0] rx [12] = '{Z, 32'h7FFF_FFFF, 32'h8000_0000, Z, Z, Z, UP, Z, 32'h7FFF_FFFF, Z, Z, Z};
    logic [11:0] re = 12'hE00;
    fcm_fast_counter #(.UPDATE_CYCLES(UP)) u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .enc_a({5'h00, ea}), .enc_b({5'h00, eb}), .enc_n(4'h0),
        .counter_aux_input(aux), .counter_out(counter_out));
    fcm_enc_model u_enc (.pclk(pclk), .presetn(presetn), .step(step), .down(down), .mode(emode),
        .a(ea), .b(eb));
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic test_done();
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Holds the request until ready is seen at an edge, then releases
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (pready !== 1'b1)
        begin
            mismatches++;
            $display("MISMATCH %0t bus timeout", $time);
            test_done();
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] o, input logic [31:0] d);
        apb(1'b1, {6'h00, o}, d);
    endtask
    task automatic rdc(input logic [5:0] o, input logic [31:0] e);
        apb(1'b0, {6'h00, o}, Z);
        chk(rd, e);
    endtask
    task automatic move(input int n, input logic dn);
        repeat (n)
        begin
            @(posedge pclk);
            step <= 1'b1;
            down <= dn;
            @(posedge pclk);
            step <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
    endtask
    task automatic pin(input int i, input logic v);
        @(posedge pclk);
        aux[i] <= v;
        repeat (6) @(posedge pclk);
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, step, down} = 6'h00;
        clk_en = 1'b1;
        {paddr, pwdata, aux, emode} = 58'h0;
        repeat (6) @(posedge pclk);
        chk(32'(counter_out), Z);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'(counter_out), 32'h0000_003F);
        for (int i = 0; i < 12; i++)
        begin
            apb(1'b0, ra[i], Z);
            chk(rd, rx[i]);
            chk(32'(rerr), 32'(re[i]));
        end
        wr(6'h1C, 32'h0000_0055);
        rdc(6'h1C, Z);
        wr(6'h10, 32'h0000_0003);
        wr(6'h14, 32'h0000_0002);
        move(3, 1'b0);
        rdc(6'h1C, Z);
        wr(6'h00, 32'h0000_0001);
        move(5, 1'b0);
        rdc(6'h1C, 32'h0000_0005);
        move(4, 1'b1);
        rdc(6'h1C, 32'h0000_0001);
        chk(32'(counter_out[0]), 32'h0000_0001);
        move(6, 1'b1);
        // Exact rate depends on window phase; only the sign is fixed
        apb(1'b0, 12'h024, Z);
        chk(32'(rerr), Z);
        chk(32'(rd[31]), 32'h0000_0001);
        rdc(6'h1C, 32'hFFFF_FFFB);
        chk(32'(counter_out[0]), Z);
        wr(6'h00, Z);
        apb(1'b0, 12'h024, Z);
        m1 = rd;
        move(3, 1'b0);
        rdc(6'h24, m1);
        rdc(6'h1C, 32'hFFFF_FFFB);
        wr(6'h04, 32'h0000_0002);
        wr(6'h08, 32'hFFFF_FFFB);
        wr(6'h0C, 32'h0000_0009);
        rdc(6'h0C, 32'h0000_0002);
        wr(6'h0C, 32'hFFFF_FFFE);
        wr(6'h00, 32'h0000_0021);
        move(8, 1'b0);
        rdc(6'h1C, 32'hFFFF_FFFB);
        wr(6'h00, 32'h0000_0011);
        move(10, 1'b0);
        rdc(6'h1C, 32'hFFFF_FFFE);
        apb(1'b0, 12'h028, Z);
        chk(32'(rd[2]), 32'h0000_0001);
        wr(6'h00, Z);
        wr(6'h00, 32'h0000_0001);
        move(3, 1'b0);
        wr(6'h00, Z);
        wr(6'h00, 32'h0000_0041);
        rdc(6'h1C, 32'hFFFF_FFFE);
        move(3, 1'b0);
        pin(1, 1'b1);
        rdc(6'h20, 32'h0000_0001);
        wr(6'h00, 32'h0000_0441);
        pin(1, 1'b0);
        move(1, 1'b0);
        pin(1, 1'b1);
        rdc(6'h20, 32'h0000_0002);
        rdc(6'h1C, 32'hFFFF_FFFE);
        wr(6'h00, 32'h0000_0003);
        move(2, 1'b0);
        rdc(6'h1C, 32'hFFFF_FFFE);
        pin(0, 1'b1);
        move(2, 1'b0);
        rdc(6'h1C, Z);
        wr(6'h08, 32'h8000_0000);
        // Pulse modes; mode 2 has no direction track, so the program sets down
        for (int m = 1; m < 4; m++)
        begin
            wr(6'h00, 32'(m << 11) | (m == 2 ? 32'h0000_000D : 32'h0000_0001));
            @(posedge pclk);
            emode <= 2'(m);
            repeat (8) @(posedge pclk);
            apb(1'b0, 12'h01C, Z);
            m1 = rd;
            move(3, 1'b1);
            rdc(6'h1C, m1 - 32'h0000_0003);
        end
        // Clock enable low freezes the pin stages, so these steps are lost
        @(posedge pclk);
        clk_en <= 1'b0;
        move(2, 1'b1);
        clk_en <= 1'b1;
        rdc(6'h1C, 32'hFFFF_FFF7);
        test_done();
    end
endmodule
`default_nettype wire
